/* verilog/mbr_slave.sv */
// Device end: decodes read queries 01/02/03 and streams the response
// Function
// [R1] Function 01 returns coils, addressed only
// [R2] Query carries address, function, start, count
// [R3] Coil read at most 2000 points
// [R4] Coil addresses zero based on wire
// [R5] Bit reply: address, function, count, data, check
// [R6] One bit per point, first in LSB
// [R7] Unused high bits of last byte zero
// [R8] Byte count counts binary data bytes
// [R9] Values sampled at scan end, per-scan limits
// [R10] Function 02 returns inputs, same layout
// [R11] Input read at most 2000 points
// [R12] Input addresses zero based on wire
// [R13] Function 03 returns registers, at most 125
// [R14] Register addresses zero based on wire
// [R15] No reply to broadcast register read
// [R16] Register reply carries one-byte data count
// [R17] Registers two bytes, high first, ascending
// [R18] Address zero broadcast, writes only
// [R19] CRC-16 low byte first, bad frames dropped
// [R20] Foreign address ignored, line stays idle
`timescale 1ns/1ps
`default_nettype none
module mbr_slave #(
	parameter int LIM_BITS = mbr_pkg::MAX_BITS,
	parameter int LIM_REGS = mbr_pkg::MAX_REGS
) (
	input  wire logic  i_clk,
	input  wire logic  i_nrst,
	mbr_link_if.dev    link,
	input  wire logic [7:0]  i_own_adr,
	output var  logic        o_rd_req,
	output var  logic [1:0]  o_rd_space,
	output var  logic [15:0] o_rd_addr,
	input  wire logic        i_rd_ack,
	input  wire logic [15:0] i_rd_data,
	output var  logic        o_busy
);
	import mbr_pkg::*;

	if (LIM_BITS < 1 || LIM_BITS > MAX_BITS || LIM_REGS < 1 ||
		LIM_REGS > MAX_REGS) begin : g_chk
		$error("mbr_slave: point limits out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// State
	typedef enum logic [2:0] {
		S_RX, S_DEC, S_HDR, S_FETCH, S_SEND, S_CRC
	} mbr_st_t;

	typedef struct packed {
		mbr_st_t     st;
		logic [3:0]  ri;
		logic [7:0]  adr;
		logic [7:0]  fn;
		logic [15:0] sa;
		logic [15:0] qt;
		logic [15:0] crc;
		logic [7:0]  bc;
		logic [15:0] pa;
		logic [15:0] rem;
		logic [2:0]  bp;
		logic [15:0] sh;
		logic        hi;
		logic [1:0]  hs;
		logic [7:0]  exc;
		logic        req;
		logic        vld;
		logic        last;
		logic [7:0]  dat;
	} mbr_slv_t;

	mbr_slv_t state_r;
	mbr_slv_t state_nxt;
	logic     is_bits;

	function automatic logic bit_fn(input logic [7:0] f);
		return f == FC_RD_COILS || f == FC_RD_INPUTS;
	endfunction

	assign is_bits = bit_fn(state_r.fn);

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic       emit;
		logic       upd;
		logic [7:0] b;
		logic [3:0] ri1;
		state_nxt = state_r;
		emit = 1'b0;
		upd = 1'b0;
		b = 8'h00;
		ri1 = (state_r.ri == 4'hf) ? state_r.ri : state_r.ri + 4'h1;
		state_nxt.vld = 1'b0;
		state_nxt.last = 1'b0;
		case (state_r.st)
		S_RX: begin
			// Bytes are only taken here, so a query during a reply is lost
			if (link.q_vld) begin
				state_nxt.crc = crc16_upd(state_r.crc, link.q_dat); // [R19]
				state_nxt.ri = ri1;
				case (state_r.ri) // [R2]
				4'h0: state_nxt.adr = link.q_dat;
				4'h1: state_nxt.fn = link.q_dat;
				4'h2: state_nxt.sa[15:8] = link.q_dat;
				4'h3: state_nxt.sa[7:0] = link.q_dat;
				4'h4: state_nxt.qt[15:8] = link.q_dat;
				4'h5: state_nxt.qt[7:0] = link.q_dat;
				default: ;
				endcase
				if (link.q_last) begin
					state_nxt.ri = 4'h0;
					state_nxt.crc = CRC_INIT;
					// Residue zero means the check matched [R19]
					if (ri1 == QRY_LEN &&
						crc16_upd(state_r.crc, link.q_dat) == 16'h0000 &&
						state_r.adr == i_own_adr && // [R20]
						state_r.adr != BCAST_ADR) begin // [R1] [R10] [R15] [R18]
						state_nxt.st = S_DEC;
					end
				end
			end
		end
		S_DEC: begin
			state_nxt.exc = 8'h00;
			state_nxt.hs = 2'd0;
			state_nxt.pa = state_r.sa; // [R4] [R12] [R14]
			state_nxt.rem = state_r.qt;
			state_nxt.bp = 3'd0;
			state_nxt.sh = 16'h0000;
			if (!(bit_fn(state_r.fn) || state_r.fn == FC_RD_HOLD)) begin
				state_nxt.exc = EXC_ILL_FUNC;
			end else if (state_r.qt == 16'h0000 ||
				(is_bits && state_r.qt > 16'(LIM_BITS)) || // [R3] [R11]
				(!is_bits && state_r.qt > 16'(LIM_REGS))) begin // [R13]
				state_nxt.exc = EXC_ILL_VALUE;
			end
			// Binary byte count, never the ASCII character count [R8]
			if (is_bits) begin
				state_nxt.bc = 8'((state_r.qt + 16'd7) >> 3);
			end else begin
				state_nxt.bc = 8'(state_r.qt << 1); // [R16]
			end
			state_nxt.st = S_HDR;
		end
		S_HDR: begin
			emit = 1'b1;
			upd = 1'b1;
			state_nxt.hs = state_r.hs + 2'd1;
			case (state_r.hs) // [R5]
			2'd0: b = state_r.adr;
			2'd1: b = (state_r.exc != 8'h00) ? (state_r.fn | EXC_FLAG) :
				state_r.fn;
			default: begin
				b = (state_r.exc != 8'h00) ? state_r.exc : state_r.bc;
				state_nxt.st = (state_r.exc != 8'h00) ? S_CRC : S_FETCH;
			end
			endcase
		end
		S_FETCH: begin
			// Handshake lets user logic answer with end-of-scan values [R9]
			if (is_bits && state_r.rem == 16'h0000) begin
				state_nxt.sh[7:0] = {1'b0, state_r.sh[7:1]}; // [R7]
				state_nxt.bp = state_r.bp + 3'd1;
				if (state_r.bp == 3'd7) begin
					state_nxt.st = S_SEND;
				end
			end else if (!state_r.req) begin
				state_nxt.req = 1'b1;
			end else if (i_rd_ack) begin
				state_nxt.req = 1'b0;
				state_nxt.pa = state_r.pa + 16'd1;
				state_nxt.rem = state_r.rem - 16'd1;
				if (is_bits) begin
					// First point lands in bit 0 after eight shifts [R6]
					state_nxt.sh[7:0] = {i_rd_data[0], state_r.sh[7:1]};
					state_nxt.bp = state_r.bp + 3'd1;
					if (state_r.bp == 3'd7) begin
						state_nxt.st = S_SEND;
					end
				end else begin
					state_nxt.sh = i_rd_data;
					state_nxt.hi = 1'b1;
					state_nxt.st = S_SEND;
				end
			end
		end
		S_SEND: begin
			emit = 1'b1;
			upd = 1'b1;
			state_nxt.bc = state_r.bc - 8'd1;
			if (is_bits) begin
				b = state_r.sh[7:0];
			end else begin
				b = state_r.hi ? state_r.sh[15:8] : state_r.sh[7:0]; // [R17]
				state_nxt.hi = 1'b0;
			end
			if (state_r.bc == 8'd1) begin
				state_nxt.st = S_CRC;
			end else if (!is_bits && state_r.hi) begin
				state_nxt.st = S_SEND;
			end else begin
				state_nxt.st = S_FETCH;
			end
		end
		S_CRC: begin
			emit = 1'b1;
			state_nxt.hi = ~state_r.hi;
			b = state_r.hi ? state_r.crc[15:8] : state_r.crc[7:0]; // [R19]
			if (state_r.hi) begin
				state_nxt.last = 1'b1;
				state_nxt.hi = 1'b0;
				state_nxt.crc = CRC_INIT;
				state_nxt.st = S_RX;
			end
		end
		default: state_nxt.st = S_RX;
		endcase
		if (emit) begin
			state_nxt.vld = 1'b1;
			state_nxt.dat = b;
		end
		if (upd) begin
			state_nxt.crc = crc16_upd(state_r.crc, b);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r <= '0;
			state_r.st <= S_RX;
			state_r.crc <= CRC_INIT;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign link.r_vld = state_r.vld;
	assign link.r_dat = state_r.dat;
	assign link.r_last = state_r.last;
	assign o_rd_req = state_r.req;
	assign o_rd_space = state_r.fn[1:0];
	assign o_rd_addr = state_r.pa;
	assign o_busy = state_r.st != S_RX;

endmodule
`default_nettype wire

/* verilog/mbr_pkg.sv */
// Shared constants, CRC helper and reply timeout for the read-function master and responder
package mbr_pkg;

	////////////////////////////////////////////////////////////////////////
	// Function and exception codes
	localparam logic [7:0] FC_RD_COILS   = 8'h01;
	localparam logic [7:0] FC_RD_INPUTS  = 8'h02;
	localparam logic [7:0] FC_RD_HOLD    = 8'h03;
	localparam logic [7:0] EXC_FLAG      = 8'h80;
	localparam logic [7:0] EXC_ILL_FUNC  = 8'h01;
	localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
	localparam logic [7:0] BCAST_ADR     = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Limits and frame layout
	localparam int          MAX_BITS  = 2000;
	localparam int          MAX_REGS  = 125;
	localparam logic [3:0]  QRY_LEN   = 4'h8;
	localparam logic [3:0]  IDX_CRC_H = 4'h7;
	localparam logic [15:0] CRC_INIT  = 16'hffff;
	localparam logic [15:0] CRC_POLY  = 16'ha001;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_MHZ     = 100;
	localparam int RSP_TMO_US  = 1000;
	localparam int RSP_TMO_CYC = RSP_TMO_US * CLK_MHZ;

	// One byte into the reflected CRC-16, LSB first
	function automatic logic [15:0] crc16_upd(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] x;
		x = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
		end
		return x;
	endfunction

endpackage

/* verilog/mbr_link_if.sv */
// Byte-stream link between the query master and the read responder
`timescale 1ns/1ps
`default_nettype none
interface mbr_link_if;
	logic       q_vld;
	logic [7:0] q_dat;
	logic       q_last;
	logic       r_vld;
	logic [7:0] r_dat;
	logic       r_last;

	modport host (output q_vld, q_dat, q_last, input r_vld, r_dat, r_last);
	modport dev  (input q_vld, q_dat, q_last, output r_vld, r_dat, r_last);
endinterface
`default_nettype wire

/* verilog/mbr_master.sv */
// Host end: builds a read query with CRC and collects the reply
`timescale 1ns/1ps
`default_nettype none
module mbr_master #(
	parameter int TMO_CYC = mbr_pkg::RSP_TMO_CYC
) (
	input  wire logic  i_clk,
	input  wire logic  i_nrst,
	mbr_link_if.host   link,
	input  wire logic        i_req,
	input  wire logic [7:0]  i_slave,
	input  wire logic [7:0]  i_func,
	input  wire logic [15:0] i_start,
	input  wire logic [15:0] i_qty,
	output var  logic        o_busy,
	output var  logic        o_rej,
	output var  logic        o_rsp_vld,
	output var  logic [7:0]  o_rsp_byte,
	output var  logic        o_done,
	output var  logic        o_crc_ok,
	output var  logic        o_timeout
);
	import mbr_pkg::*;

	if (TMO_CYC < 1 || TMO_CYC > 32'h00ffffff) begin : g_chk
		$error("mbr_master: timeout out of range");
	end

	typedef enum logic [1:0] {M_IDLE, M_SEND, M_WAIT} mbr_mst_t;

	typedef struct packed {
		mbr_mst_t    st;
		logic [2:0]  ti;
		logic [63:0] q;
		logic [15:0] crc;
		logic [23:0] tmo;
		logic        rej;
		logic        qv;
		logic        ql;
		logic [7:0]  qd;
		logic        rv;
		logic [7:0]  rd;
		logic        done;
		logic        ok;
		logic        to;
	} mbr_mst_s_t;

	mbr_mst_s_t state_r;
	mbr_mst_s_t state_nxt;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic [7:0] b;
		state_nxt = state_r;
		b = state_r.q[63:56];
		state_nxt.rej = 1'b0;
		state_nxt.qv = 1'b0;
		state_nxt.ql = 1'b0;
		state_nxt.rv = 1'b0;
		state_nxt.done = 1'b0;
		case (state_r.st)
		M_IDLE: begin
			if (i_req) begin
				// Reads are never broadcast and limits apply [R3] [R11] [R13] [R18]
				if (i_slave == BCAST_ADR || i_qty == 16'h0000 ||
					!(i_func == FC_RD_COILS || i_func == FC_RD_INPUTS ||
					i_func == FC_RD_HOLD) ||
					(i_func == FC_RD_HOLD && i_qty > 16'(MAX_REGS)) ||
					(i_func != FC_RD_HOLD && i_qty > 16'(MAX_BITS))) begin
					state_nxt.rej = 1'b1;
				end else begin
					// Start taken as zero-based wire address [R4] [R12] [R14]
					state_nxt.q = {i_slave, i_func, i_start, i_qty, 16'h0000}; // [R2]
					state_nxt.ti = 3'd0;
					state_nxt.crc = CRC_INIT;
					state_nxt.st = M_SEND;
				end
			end
		end
		M_SEND: begin
			state_nxt.qv = 1'b1;
			state_nxt.ti = state_r.ti + 3'd1;
			if ({1'b0, state_r.ti} < IDX_CRC_H - 4'h1) begin
				state_nxt.crc = crc16_upd(state_r.crc, b);
				state_nxt.q = {state_r.q[55:0], 8'h00};
			end else if ({1'b0, state_r.ti} == IDX_CRC_H - 4'h1) begin
				b = state_r.crc[7:0]; // [R19]
			end else begin
				b = state_r.crc[15:8];
				state_nxt.ql = 1'b1;
				state_nxt.crc = CRC_INIT;
				state_nxt.tmo = 24'h000000;
				state_nxt.st = M_WAIT;
			end
			state_nxt.qd = b;
		end
		M_WAIT: begin
			state_nxt.tmo = state_r.tmo + 24'h000001;
			if (link.r_vld) begin
				state_nxt.rv = 1'b1;
				state_nxt.rd = link.r_dat;
				state_nxt.crc = crc16_upd(state_r.crc, link.r_dat); // [R19]
				if (link.r_last) begin
					state_nxt.done = 1'b1;
					state_nxt.ok = crc16_upd(state_r.crc, link.r_dat) == 16'h0000;
					state_nxt.to = 1'b0;
					state_nxt.st = M_IDLE;
				end
			end else if (state_r.tmo == 24'(TMO_CYC - 1)) begin
				// A silent slave must not hang the host forever [R20]
				state_nxt.done = 1'b1;
				state_nxt.ok = 1'b0;
				state_nxt.to = 1'b1;
				state_nxt.st = M_IDLE;
			end
		end
		default: state_nxt.st = M_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r <= '0;
			state_r.st <= M_IDLE;
			state_r.crc <= CRC_INIT;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign link.q_vld = state_r.qv;
	assign link.q_dat = state_r.qd;
	assign link.q_last = state_r.ql;
	assign o_busy = state_r.st != M_IDLE;
	assign o_rej = state_r.rej;
	assign o_rsp_vld = state_r.rv;
	assign o_rsp_byte = state_r.rd;
	assign o_done = state_r.done;
	assign o_crc_ok = state_r.ok;
	assign o_timeout = state_r.to;

endmodule
`default_nettype wire

/* testbench/mbr_link_asserts.sv */
// Link assertions for the read responder pair
`timescale 1ns/1ps
`default_nettype none
module mbr_link_asserts
	import mbr_pkg::*;
#(
	parameter logic [7:0] OWN_ADR = 8'h0b
) (
	input wire logic       i_clk,
	input wire logic       i_nrst,
	input wire logic       q_vld,
	input wire logic [7:0] q_dat,
	input wire logic       q_last,
	input wire logic       r_vld,
	input wire logic [7:0] r_dat,
	input wire logic       r_last
);
	logic [3:0]  qi_r;
	logic [7:0]  adr_r, fn_r;
	logic [15:0] qty_r, ri_r, cnt;
	logic        act_r, qend;
	assign qend = q_vld && q_last;
	// Two bytes a register, one a started group of eight points
	assign cnt = (fn_r == FC_RD_HOLD) ? qty_r << 1 : (qty_r + 16'h7) >> 3;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			qi_r <= 4'h0;
			adr_r <= 8'h0;
			fn_r <= 8'h0;
			qty_r <= 16'h0;
			ri_r <= 16'h0;
			act_r <= 1'b0;
		end else begin
			if (q_vld) begin
				qi_r <= q_last ? 4'h0 : qi_r + 4'h1;
				if (qi_r == 4'h0) adr_r <= q_dat;
				if (qi_r == 4'h1) fn_r <= q_dat;
				if (qi_r == 4'h4) qty_r[15:8] <= q_dat;
				if (qi_r == 4'h5) qty_r[7:0] <= q_dat;
			end
			if (qend && adr_r == OWN_ADR) act_r <= 1'b1;
			else if (r_last) act_r <= 1'b0;
			if (r_vld) ri_r <= r_last ? 16'h0 : ri_r + 16'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	AST_IDLE: assert property (!act_r |-> !r_vld)
		else $error("reply byte with no query taken");
	// Last-byte capture, decode and header step (into the output register) each take one edge
	AST_ADR: assert property (qend && adr_r == OWN_ADR |-> ##3
		r_vld && r_dat == adr_r) else $error("reply address wrong");
	AST_FN: assert property (qend && adr_r == OWN_ADR |-> ##4
		r_vld && r_dat == fn_r) else $error("reply function wrong");
	AST_CNT: assert property (qend && adr_r == OWN_ADR |-> ##5
		r_vld && r_dat == cnt[7:0]) else $error("byte count wrong");
	AST_PAD: assert property (r_vld && fn_r != FC_RD_HOLD &&
		ri_r == cnt + 16'h2 && qty_r[2:0] != 3'h0 |->
		(r_dat >> qty_r[2:0]) == 8'h0) else $error("fill bits set");
	AST_LEN: assert property (r_last |-> r_vld && ri_r == cnt + 16'h4)
		else $error("reply length wrong");
	AST_REG: assert property (r_last && fn_r == FC_RD_HOLD |->
		ri_r == (qty_r << 1) + 16'h4) else $error("register reply length");
	AST_FOREIGN: assert property (qend && adr_r != OWN_ADR |=>
		!r_vld [*6]) else $error("reply to foreign address");
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench: master and responder face each other
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import mbr_pkg::*;
	localparam logic [7:0] OWN_ADR = 8'h0b;
	logic        clk = 1'b0, nrst = 1'b0, req = 1'b0, ack = 1'b0;
	logic        rej, rvld, done, crc_ok, tmo, rq1, rq2, busy2, mbusy;
	logic [7:0]  slv = 8'h0, fnc = 8'h0, rbyte;
	logic [15:0] st = 16'h0, qt = 16'h0, dat1 = 16'h0, ad1, ad2;
	logic [1:0]  sp1, sp2;
	logic [7:0]  exp[$];
	int          fail_count, samples_checked, seed;
	mbr_link_if link ();
	mbr_link_if lk2 ();
	// Reply timer runs for the whole reply, so it must outlast 2000 points
	mbr_master #(.TMO_CYC(12000)) i_mbr_master (.i_clk(clk), .i_nrst(nrst),
		.link(link.host), .i_req(req), .i_slave(slv), .i_func(fnc),
		.i_start(st), .i_qty(qt), .o_busy(mbusy), .o_rej(rej),
		.o_rsp_vld(rvld),
		.o_rsp_byte(rbyte), .o_done(done), .o_crc_ok(crc_ok),
		.o_timeout(tmo));
	mbr_slave i_mbr_slave (.i_clk(clk), .i_nrst(nrst), .link(link.dev),
		.i_own_adr(OWN_ADR), .o_rd_req(rq1), .o_rd_space(sp1),
		.o_rd_addr(ad1), .i_rd_ack(ack), .i_rd_data(dat1), .o_busy());
	// Second responder faces a raw driver that can break the frame rules
	mbr_slave i_mbr_slave_b (.i_clk(clk), .i_nrst(nrst), .link(lk2.dev),
		.i_own_adr(OWN_ADR), .o_rd_req(rq2), .o_rd_space(sp2),
		.o_rd_addr(ad2), .i_rd_ack(rq2), .i_rd_data(pt(sp2, ad2)),
		.o_busy(busy2));
	mbr_link_asserts #(.OWN_ADR(OWN_ADR)) i_mbr_link_asserts (.i_clk(clk),
		.i_nrst(nrst), .q_vld(link.q_vld), .q_dat(link.q_dat),
		.q_last(link.q_last), .r_vld(link.r_vld), .r_dat(link.r_dat),
		.r_last(link.r_last));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] pt(input logic [1:0] s,
		input logic [15:0] a);
		return (a * 16'h9e37) ^ {s, 14'h15a3};
	endfunction
	function automatic logic [15:0] crcq(input logic [7:0] d[$]);
		logic [15:0] c;
		c = CRC_INIT;
		foreach (d[i]) begin
			c = c ^ {8'h0, d[i]};
			for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		end
		return c;
	endfunction
	task automatic addcrc();
		logic [15:0] c;
		c = crcq(exp);
		exp.push_back(c[7:0]);
		exp.push_back(c[15:8]);
	endtask
	task automatic chk8(input string n, input logic [7:0] e, g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk1(input string n, input logic e, g);
		chk8(n, {7'h0, e}, {7'h0, g});
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic mk(input logic [7:0] a, f, input logic [15:0] s, q);
		logic [15:0] v;
		logic [7:0]  b;
		exp = {a, f};
		if (f == FC_RD_HOLD) begin
			exp.push_back(8'(q * 2));
			for (int i = 0; i < q; i++) begin
				v = pt(2'h3, s + 16'(i));
				exp.push_back(v[15:8]);
				exp.push_back(v[7:0]);
			end
		end else begin
			exp.push_back(8'((q + 7) / 8));
			for (int i = 0; i < (q + 7) / 8; i++) begin
				for (int j = 0; j < 8; j++) begin
					v = pt(f[1:0], s + 16'(i * 8 + j));
					b[j] = (i * 8 + j < q) && v[0];
				end
				exp.push_back(b);
			end
		end
		addcrc();
	endtask
	task automatic run(input logic [7:0] a, f, input logic [15:0] s, q,
		input logic r);
		int n;
		if (a == OWN_ADR) mk(a, f, s, q);
		else exp.delete();
		@(posedge clk);
		req <= 1'b1;
		slv <= a;
		fnc <= f;
		st <= s;
		qt <= q;
		@(posedge clk);
		req <= 1'b0;
		if (r) begin
			#1;
			chk1("refused", 1'b1, rej);
			chk1("master busy", 1'b0, mbusy);
			return;
		end
		for (n = 0; n < 20000 && !done; n++) begin
			@(posedge clk);
			#1;
			if (rvld) chk8("reply", exp.pop_front(), rbyte);
			chk1("master busy", !done, mbusy);
		end
		if (!done) begin
			fail_count++;
			close_out();
		end
		chk1("timeout", a != OWN_ADR, tmo);
		if (a == OWN_ADR) chk1("check", 1'b1, crc_ok);
		chk8("left", 8'h0, 8'(exp.size()));
	endtask
	task automatic raw(input logic [7:0] a, f, input logic [15:0] q,
		input logic [7:0] bad, x);
		logic [7:0]  t[$];
		logic [15:0] c;
		t = {a, f, 8'h0, 8'h0, q[15:8], q[7:0]};
		c = crcq(t);
		t.push_back(c[7:0] ^ bad);
		t.push_back(c[15:8]);
		exp.delete();
		if (x != 8'h0) begin
			exp = {a, f | EXC_FLAG, x};
			addcrc();
		end
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			lk2.q_vld <= 1'b1;
			lk2.q_dat <= t[i];
			lk2.q_last <= (i == 7);
		end
		@(posedge clk);
		lk2.q_vld <= 1'b0;
		lk2.q_last <= 1'b0;
		repeat (30) begin
			@(posedge clk);
			#1;
			if (lk2.r_vld) chk8("raw", exp.pop_front(), lk2.r_dat);
			if (x == 8'h0) chk1("busy", 1'b0, busy2);
		end
		chk8("raw left", 8'h0, 8'(exp.size()));
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		forever #5 clk = ~clk;
	end
	// Random stall on the point fetch, as user logic waiting for scan end
	always @(posedge clk) begin
		ack <= rq1 && !ack && ($random(seed) & 1) != 0;
		dat1 <= pt(sp1, ad1);
	end
	initial begin
		logic [7:0] f;
		seed = 79825;
		lk2.q_vld = 1'b0;
		lk2.q_dat = 8'h0;
		lk2.q_last = 1'b0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		run(OWN_ADR, FC_RD_COILS, 16'h0013, 16'h0025, 1'b0);
		run(OWN_ADR, FC_RD_INPUTS, 16'h00c4, 16'h0016, 1'b0);
		run(OWN_ADR, FC_RD_HOLD, 16'h006b, 16'h0003, 1'b0);
		run(OWN_ADR, FC_RD_COILS, 16'h0000, 16'd2000, 1'b0);
		run(OWN_ADR, FC_RD_INPUTS, 16'h0001, 16'd2000, 1'b0);
		run(OWN_ADR, FC_RD_HOLD, 16'h0100, 16'd125, 1'b0);
		run(OWN_ADR, FC_RD_COILS, 16'h0000, 16'h0001, 1'b0);
		run(8'h0c, FC_RD_HOLD, 16'h0000, 16'h0001, 1'b0);
		repeat (6) begin
			f = 8'(1 + (($random(seed) & 32'hff) % 3));
			run(OWN_ADR, f, 16'($random(seed) & 32'hfff),
				16'(1 + ($random(seed) & 32'h3f)), 1'b0);
		end
		run(BCAST_ADR, FC_RD_HOLD, 16'h0, 16'h1, 1'b1);
		run(OWN_ADR, FC_RD_COILS, 16'h0, 16'h0, 1'b1);
		run(OWN_ADR, FC_RD_INPUTS, 16'h0, 16'd2001, 1'b1);
		run(OWN_ADR, FC_RD_HOLD, 16'h0, 16'd126, 1'b1);
		raw(BCAST_ADR, FC_RD_HOLD, 16'h1, 8'h0, 8'h0);
		raw(BCAST_ADR, FC_RD_COILS, 16'h1, 8'h0, 8'h0);
		raw(BCAST_ADR, FC_RD_INPUTS, 16'h1, 8'h0, 8'h0);
		raw(8'h0c, FC_RD_HOLD, 16'h1, 8'h0, 8'h0);
		raw(OWN_ADR, FC_RD_HOLD, 16'h1, 8'h01, 8'h0);
		raw(OWN_ADR, 8'h04, 16'h1, 8'h0, EXC_ILL_FUNC);
		raw(OWN_ADR, FC_RD_COILS, 16'd2001, 8'h0, EXC_ILL_VALUE);
		raw(OWN_ADR, FC_RD_INPUTS, 16'h0, 8'h0, EXC_ILL_VALUE);
		raw(OWN_ADR, FC_RD_HOLD, 16'd126, 8'h0, EXC_ILL_VALUE);
		close_out();
	end
endmodule
`default_nettype wire
